// >>> design/four_bit_exec.sv
// instruction executor of a 4-bit core: loads, ports, bits, skips, returns, timer transfers
`timescale 1ns/10ps
`default_nettype none
`include "four_bit_exec_cfg.svh"

//////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - load_immediate_acc loads A; a run of them executes only the first.
// - acc_boolean_combine applies XOR, OR or AND of A and E into A.
// - acc_to_port_e_out drives A1 and A0 onto the two port E outputs.
// - acc_to_port_g_out drives all four accumulator bits onto port G.
// - clear_mem_bit clears bit j of the RAM word at the data pointer.
// - modulated_flag_set and modulated_flag_clear set and clear the carrier output flag.
// - clear_port_d_bit clears port D bit Y (high impedance), Y 0 to 7 only.
// - set_port_d_bit sets port D bit Y to one.
// - subroutine_return reloads PC from the stack, pops it, takes two cycles.
// - return_and_skip returns like subroutine_return then always skips the next word.
// - skip_acc_equals_imm, two words, two cycles, skips when A equals immediate.
// - skip_acc_equals_mem skips when A equals the RAM word at the data pointer.
// - skip_on_powerdown_flag skips when power-down flag is one, flag unchanged.
// - skip_on_timer2_request skips when the timer 2 request flag is set.
// - after that skip the timer 2 request flag is cleared, unless t2_req is high in the same cycle.
// - skip_mem_bit_zero skips when bit j of the RAM word at the pointer is zero.
// - skip_port_d_bit_zero, two words, skips when D bit Y is zero, Y 4 to 7.
// - load_timer1_from_regs writes B:A to reload; to counter only while timer stopped.
// - load_timer2_and_low_reload writes B:A to timer 2 counter and low reload.
// - load_timer2_high_reload writes B:A to the high reload, counter untouched.
// - copy_low_reload_to_timer2 copies the low reload into the timer 2 counter.
// - read_timer1_to_regs and read_timer2_to_regs put counter high into B, low into A.
// - read_e_register_to_regs puts E high into B and E low into A.
module four_bit_exec (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // program fetch
    output logic     [10:0]                  pc_addr,
    input  wire logic [8:0]                  instr,
    // register port
    input  wire four_bit_exec_pkg::bus_req_t bus,
    output logic     [15:0]                  rdata,
    // flag sources
    input  wire logic                        pwr_down_flag,
    input  wire logic                        t1_uflow,
    input  wire logic                        t2_req,
    // ports
    input  wire logic [7:0]                  d_in,
    output four_bit_exec_pkg::port_out_t     pins
);

    typedef struct packed {
        four_bit_exec_pkg::seq_state_t fsm;
        logic [10:0]        pc;
        logic [3:0]         a;
        logic [3:0]         b;
        logic [1:0]         x;
        logic [3:0]         y;
        logic [7:0]         e;
        logic [1:0]         lo;
        logic               run1;
        logic               modulated_output_flag;
        logic [7:0]         pd;
        logic [1:0]         pe;
        logic [3:0]         pg;
        logic               t1f;
        logic               t2f;
        logic [7:0]         t1_cnt;
        logic [7:0]         t1_rld;
        logic [7:0]         t2_cnt;
        logic [7:0]         t2_rl;
        logic [7:0]         t2_rh;
        logic [1:0]         sp;
        logic [3:0][10:0]   stk;
        logic [63:0][3:0]   ram;
        logic               skip;
        logic               la_run;
        logic               op2_szd;
        logic [15:0]        rdata;
    } core_t;

    localparam core_t RST_STATE = '{fsm: four_bit_exec_pkg::ST_EXEC, pc: `PC_RESET,
                                    default: '0};

    core_t      s;
    core_t      next_s;
    logic [5:0] dp;
    logic [3:0] mem_word;
    logic       exec_now;

    //////////////////////////////////////////////////////////////////////////////////////
    // shared decode terms
    assign dp       = {s.x, s.y};
    assign mem_word = s.ram[dp];
    assign exec_now = (s.fsm == four_bit_exec_pkg::ST_EXEC) && !s.skip;

    //////////////////////////////////////////////////////////////////////////////////////
    // next state: sequencer, instruction effects, flag events, register port
    always_comb begin
        next_s       = s;
        next_s.rdata = 16'h0000;
        unique case (s.fsm)
            four_bit_exec_pkg::ST_EXEC: begin
                next_s.pc = s.pc + 11'h001;
                if (s.skip) begin
                    // word consumed untouched; a two-word opcode drops its tail too
                    next_s.skip   = 1'b0;
                    next_s.la_run = 1'b0;
                    if (instr == `OP_SEA || instr == `OP_SZD) begin
                        next_s.fsm = four_bit_exec_pkg::ST_SKIP2;
                    end
                end else begin
                    next_s.la_run = 1'b0;
                    casez (instr)
                        `OP_LA: begin
                            next_s.la_run = 1'b1;
                            if (!s.la_run) begin
                                next_s.a = instr[3:0];
                            end
                        end
                        `OP_ACC_BOOLEAN_COMBINE: begin
                            if (s.lo == `BOOL_XOR) begin
                                next_s.a = s.a ^ s.e[3:0];
                            end else if (s.lo == `BOOL_OR) begin
                                next_s.a = s.a | s.e[3:0];
                            end else begin
                                next_s.a = s.a & s.e[3:0];
                            end
                        end
                        `OP_OEA:  next_s.pe = s.a[1:0];
                        `OP_OGA:  next_s.pg = s.a;
                        `OP_RB:   next_s.ram[dp][instr[1:0]] = 1'b0;
                        `OP_SB:   next_s.ram[dp][instr[1:0]] = 1'b1;
                        `OP_MODULATED_FLAG_SET: next_s.modulated_output_flag = 1'b1;
                        `OP_MODULATED_FLAG_CLEAR: next_s.modulated_output_flag = 1'b0;
                        `OP_RD: begin
                            if (!s.y[3]) begin
                                next_s.pd[s.y[2:0]] = 1'b0;
                            end
                        end
                        `OP_SD: begin
                            if (!s.y[3]) begin
                                next_s.pd[s.y[2:0]] = 1'b1;
                            end
                        end
                        `OP_RT, `OP_RTS: begin
                            // pop in the first cycle, the second cycle fetches nothing
                            next_s.pc   = s.stk[s.sp];
                            next_s.sp   = s.sp - 2'h1;
                            next_s.fsm  = four_bit_exec_pkg::ST_RET2;
                            next_s.skip = (instr == `OP_RTS);
                        end
                        `OP_SEA: begin
                            next_s.op2_szd = 1'b0;
                            next_s.fsm     = four_bit_exec_pkg::ST_WORD2;
                        end
                        `OP_SZD: begin
                            next_s.op2_szd = 1'b1;
                            next_s.fsm     = four_bit_exec_pkg::ST_WORD2;
                        end
                        `OP_SKIP_ACC_EQUALS_MEM:  next_s.skip = (s.a == mem_word);
                        `OP_SKIP_ON_POWERDOWN_FLAG:  next_s.skip = pwr_down_flag;
                        `OP_SKIP_ON_TIMER1_UNDERFLOW: begin
                            next_s.skip = s.t1f;
                            next_s.t1f  = 1'b0;
                        end
                        `OP_SKIP_ON_TIMER2_REQUEST: begin
                            next_s.skip = s.t2f;
                            next_s.t2f  = 1'b0;
                        end
                        `OP_SZB:   next_s.skip = !mem_word[instr[1:0]];
                        `OP_LOAD_TIMER1_FROM_REGS: begin
                            next_s.t1_rld = {s.b, s.a};
                            if (!s.run1) begin
                                next_s.t1_cnt = {s.b, s.a};
                            end
                        end
                        `OP_LOAD_TIMER2_AND_LOW_RELOAD: begin
                            next_s.t2_cnt = {s.b, s.a};
                            next_s.t2_rl  = {s.b, s.a};
                        end
                        `OP_LOAD_TIMER2_HIGH_RELOAD: next_s.t2_rh  = {s.b, s.a};
                        `OP_COPY_LOW_RELOAD_TO_TIMER2: next_s.t2_cnt = s.t2_rl;
                        `OP_READ_TIMER1_TO_REGS:  {next_s.b, next_s.a} = s.t1_cnt;
                        `OP_READ_TIMER2_TO_REGS:  {next_s.b, next_s.a} = s.t2_cnt;
                        `OP_READ_E_REGISTER_TO_REGS:  {next_s.b, next_s.a} = s.e;
                        default:   next_s.la_run = 1'b0;
                    endcase
                end
            end
            four_bit_exec_pkg::ST_WORD2: begin
                // second word: immediate of the compare, or the port D test
                next_s.pc  = s.pc + 11'h001;
                next_s.fsm = four_bit_exec_pkg::ST_EXEC;
                if (s.op2_szd) begin
                    next_s.skip = (s.y[3:2] == 2'b01) && !d_in[s.y[2:0]];
                end else begin
                    next_s.skip = (s.a == instr[3:0]);
                end
            end
            four_bit_exec_pkg::ST_SKIP2: begin
                next_s.pc  = s.pc + 11'h001;
                next_s.fsm = four_bit_exec_pkg::ST_EXEC;
            end
            four_bit_exec_pkg::ST_RET2: begin
                next_s.fsm = four_bit_exec_pkg::ST_EXEC;
            end
            default: next_s = RST_STATE;
        endcase

        // timer events set their flags; a set wins over a clear in the same cycle
        if (t1_uflow) begin
            next_s.t1f = 1'b1;
        end
        if (t2_req) begin
            next_s.t2f = 1'b1;
        end

        // register port writes take priority over the instruction
        if (bus.wr) begin
            unique case (bus.addr)
                `REG_CTRL: begin
                    next_s.lo   = bus.wdata[1:0];
                    next_s.run1 = bus.wdata[`CTRL_RUN1_BIT];
                end
                `REG_ACC:    {next_s.b, next_s.a} = bus.wdata[7:0];
                `REG_PTR:    {next_s.x, next_s.y} = bus.wdata[5:0];
                `REG_EREG:   next_s.e = bus.wdata[7:0];
                `REG_RAM:    next_s.ram[dp] = bus.wdata[3:0];
                `REG_PUSH: begin
                    next_s.sp = s.sp + 2'h1;
                    next_s.stk[s.sp + 2'h1] = bus.wdata[10:0];
                end
                `REG_PC:     next_s.pc = bus.wdata[10:0];
                `REG_TIMER1: next_s.t1_cnt = bus.wdata[7:0];
                `REG_TIMER2: next_s.t2_cnt = bus.wdata[7:0];
                default:     next_s.la_run = next_s.la_run;
            endcase
        end

        // register port reads, answered one cycle later
        if (bus.rd) begin
            unique case (bus.addr)
                `REG_CTRL:   next_s.rdata = {13'h0000, s.run1, s.lo};
                `REG_ACC:    next_s.rdata = {8'h00, s.b, s.a};
                `REG_PTR:    next_s.rdata = {10'h000, s.x, s.y};
                `REG_EREG:   next_s.rdata = {8'h00, s.e};
                `REG_RAM:    next_s.rdata = {12'h000, mem_word};
                `REG_PUSH:   next_s.rdata = {14'h0000, s.sp};
                `REG_PC:     next_s.rdata = {5'h00, s.pc};
                `REG_STATUS: next_s.rdata = {s.fsm, 6'h00, s.skip, s.la_run,
                                             s.modulated_output_flag, pwr_down_flag, s.t2f, s.t1f};
                `REG_TIMER1: next_s.rdata = {s.t1_rld, s.t1_cnt};
                `REG_TIMER2: next_s.rdata = {s.t2_rl, s.t2_cnt};
                `REG_T2HIGH: next_s.rdata = {8'h00, s.t2_rh};
                default:     next_s.rdata = 16'h0000;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register
    assign pc_addr      = s.pc;
    assign rdata        = s.rdata;
    assign pins.d_out   = s.pd;
    assign pins.d_oe_n  = ~s.pd; // a cleared bit floats
    assign pins.e_out   = s.pe;
    assign pins.g_out   = s.pg;
    assign pins.car_pin = s.modulated_output_flag;

    //////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_la_first_load: assert property (exec_now && instr[8:4] == 5'h0B && !s.la_run && !bus.wr
        |=> s.a == $past(instr[3:0])) else $error("first load did not reach A");
    a_la_run_nop: assert property (exec_now && instr[8:4] == 5'h0B && s.la_run && !bus.wr
        |=> $stable(s.a)) else $error("repeated load changed A");
    a_car_set: assert property (exec_now && instr == `OP_MODULATED_FLAG_SET
        |=> pins.car_pin) else $error("carrier flag not set");
    a_ret_two_cycles: assert property (exec_now && instr == `OP_RT && !bus.wr
        |=> s.fsm == four_bit_exec_pkg::ST_RET2 ##1 s.fsm == four_bit_exec_pkg::ST_EXEC
        && $stable(s.pc)) else $error("return not two cycles");
    a_rts_skips: assert property (exec_now && instr == `OP_RTS
        |=> ##1 s.skip) else $error("return and skip lost its skip");
    a_sea_compare: assert property (s.fsm == four_bit_exec_pkg::ST_WORD2 && !s.op2_szd
        |=> s.skip == ($past(s.a) == $past(instr[3:0])))
        else $error("compare skip wrong");
    a_t1f_clear: assert property (exec_now && instr == `OP_SKIP_ON_TIMER1_UNDERFLOW && s.t1f && !t1_uflow
        |=> s.skip && !s.t1f) else $error("underflow flag skip or clear wrong");
    a_t1_running: assert property (exec_now && instr == `OP_LOAD_TIMER1_FROM_REGS && s.run1 && !bus.wr
        |=> $stable(s.t1_cnt) && s.t1_rld == {$past(s.b), $past(s.a)})
        else $error("running timer 1 counter overwritten");
    a_skip_port_g: assert property (s.fsm == four_bit_exec_pkg::ST_EXEC && s.skip
        |=> $stable(pins.g_out) && $stable(pins.d_out) && $stable(pins.car_pin))
        else $error("skipped word changed a port");

endmodule : four_bit_exec
`default_nettype wire

// >>> pkg/four_bit_exec_cfg.svh
// offsets, field positions, reset values and opcodes of the instruction executor
`ifndef FOUR_BIT_EXEC_CFG_SVH
`define FOUR_BIT_EXEC_CFG_SVH

// register port offsets
`define REG_CTRL       4'h0
`define REG_ACC        4'h1
`define REG_PTR        4'h2
`define REG_EREG       4'h3
`define REG_RAM        4'h4
`define REG_PUSH       4'h5
`define REG_PC         4'h6
`define REG_STATUS     4'h7
`define REG_TIMER1     4'h8
`define REG_TIMER2     4'h9
`define REG_T2HIGH     4'hA
// control register fields
`define CTRL_RUN1_BIT  2
// boolean_select_reg codes
`define BOOL_XOR       2'h0
`define BOOL_OR        2'h1
// reset value of the program counter
`define PC_RESET       11'h000
// instruction words, low bits masked with ? where they carry immediates
`define OP_LA          9'b0_1011_????
`define OP_ACC_BOOLEAN_COMBINE        9'h041
`define OP_OEA         9'h084
`define OP_OGA         9'h080
`define OP_RB          9'b0_0100_11??
`define OP_SB          9'b0_0101_11??
`define OP_MODULATED_FLAG_CLEAR        9'h086
`define OP_MODULATED_FLAG_SET        9'h087
`define OP_RD          9'h014
`define OP_SD          9'h015
`define OP_RT          9'h044
`define OP_RTS         9'h045
`define OP_SEA         9'h025
`define OP_SKIP_ACC_EQUALS_MEM        9'h026
`define OP_SKIP_ON_POWERDOWN_FLAG        9'h003
`define OP_SKIP_ON_TIMER1_UNDERFLOW       9'h042
`define OP_SKIP_ON_TIMER2_REQUEST       9'h052
`define OP_SZB         9'b0_0010_00??
`define OP_SZD         9'h024
`define OP_LOAD_TIMER1_FROM_REGS        9'h047
`define OP_LOAD_TIMER2_AND_LOW_RELOAD        9'h088
`define OP_LOAD_TIMER2_HIGH_RELOAD       9'h089
`define OP_COPY_LOW_RELOAD_TO_TIMER2       9'h053
`define OP_READ_TIMER1_TO_REGS        9'h057
`define OP_READ_TIMER2_TO_REGS        9'h040
`define OP_READ_E_REGISTER_TO_REGS        9'h02A

`endif

// >>> pkg/four_bit_exec_pkg.sv
// types of the instruction executor
package four_bit_exec_pkg;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_EXEC  = 4'b0001,
        ST_RET2  = 4'b0010,
        ST_WORD2 = 4'b0100,
        ST_SKIP2 = 4'b1000
    } seq_state_t;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // port pins driven by the core
    typedef struct packed {
        logic [7:0] d_out;
        logic [7:0] d_oe_n;
        logic [1:0] e_out;
        logic [3:0] g_out;
        logic       car_pin;
    } port_out_t;

endpackage : four_bit_exec_pkg

// >>> tb/four_bit_exec_tb.sv
// self-checking testbench of the instruction executor
`timescale 1ns/10ps
`default_nettype none
`include "four_bit_exec_cfg.svh"

module four_bit_exec_tb;
    // design ports
    logic                         sys_clk;
    logic                         rst;
    logic [10:0]                  pc_addr;
    logic [8:0]                   instr;
    four_bit_exec_pkg::bus_req_t  bus;
    logic [15:0]                  rdata;
    logic                         pwr_down_flag;
    logic                         t1_uflow;
    logic                         t2_req;
    logic [7:0]                   d_in;
    four_bit_exec_pkg::port_out_t pins;
    // bench state
    logic [8:0]                   rom [0:2047];
    logic [8:0]                   prog [$];
    logic [15:0]                  rd_val;
    int                           mismatches = 0;
    int                           checked = 0;
    int                           cycles = 0;

    four_bit_exec four_bit_exec_i (
        .sys_clk(sys_clk), .rst(rst), .pc_addr(pc_addr), .instr(instr), .bus(bus),
        .rdata(rdata), .pwr_down_flag(pwr_down_flag), .t1_uflow(t1_uflow),
        .t2_req(t2_req), .d_in(d_in), .pins(pins)
    );

    // program memory answers the fetch address at once
    assign instr = rom[pc_addr];

    ////////////////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr    <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd   <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : bus_rd

    // park the fetch at 0, load the program at 0x100, jump there
    task automatic run(input int n);
        bus_wr(`REG_PC, 16'h0000);
        for (int i = 0; i < 16; i++) rom[256 + i] = 9'h000;
        foreach (prog[i]) rom[256 + i] = prog[i];
        bus_wr(`REG_PC, 16'h0100);
        repeat (n) @(posedge sys_clk);
    endtask : run

    // skip test: a load of 7 follows, so A stays 0 only when it is skipped
    task automatic skip_case(input logic [8:0] w1, input logic [8:0] w2, input logic sk);
        bus_wr(`REG_ACC, 16'h0000);
        prog = {w1};
        if (w2 != 9'h000) prog.push_back(w2);
        prog.push_back(9'h0B7);
        run(6);
        bus_rd(`REG_ACC);
        check("skip result", 16'(rd_val[3:0]), sk ? 16'h0000 : 16'h0007);
    endtask : skip_case

    task automatic pulse(input logic two);
        @(posedge sys_clk);
        if (two) t2_req <= 1'b1; else t1_uflow <= 1'b1;
        @(posedge sys_clk);
        t1_uflow <= 1'b0;
        t2_req   <= 1'b0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_logic;
        logic [3:0] exp [3] = '{4'h9, 4'hD, 4'h4};
        bus_wr(`REG_EREG, 16'h003C);
        for (int m = 0; m < 3; m++) begin
            bus_wr(`REG_CTRL, 16'(m));
            prog = {9'h0B5, 9'h0B9, `OP_ACC_BOOLEAN_COMBINE};
            run(4);
            bus_rd(`REG_ACC);
            check("acc combine", 16'(rd_val[3:0]), 16'(exp[m]));
        end
        prog = {`OP_READ_E_REGISTER_TO_REGS};
        run(2);
        bus_rd(`REG_ACC);
        check("acc from e", 16'(rd_val[7:0]), 16'h003C);
    endtask : test_logic

    task automatic test_ports;
        bus_wr(`REG_ACC, 16'h0006);
        prog = {`OP_OGA, `OP_OEA, `OP_MODULATED_FLAG_SET};
        run(4);
        check("port g", 16'(pins.g_out), 16'h0006);
        check("port e", 16'(pins.e_out), 16'h0002);
        check("carrier on", 16'(pins.car_pin), 16'h0001);
        prog = {`OP_MODULATED_FLAG_CLEAR};
        run(2);
        check("carrier off", 16'(pins.car_pin), 16'h0000);
        bus_wr(`REG_PTR, 16'h0003);
        prog = {`OP_SD};
        run(2);
        check("port d set", {pins.d_oe_n, pins.d_out}, 16'hF708);
        prog = {`OP_RD};
        run(2);
        check("port d clear", {pins.d_oe_n, pins.d_out}, 16'hFF00);
        bus_wr(`REG_PTR, 16'h0008);
        prog = {`OP_SD};
        run(2);
        check("port d y8", {pins.d_oe_n, pins.d_out}, 16'hFF00);
    endtask : test_ports

    task automatic test_skips;
        bus_wr(`REG_PTR, 16'h0012);
        bus_wr(`REG_RAM, 16'h000F);
        prog = {9'h04E};
        run(2);
        bus_rd(`REG_RAM);
        check("ram bit clear", 16'(rd_val[3:0]), 16'h000B);
        skip_case(9'h022, 9'h000, 1'b1);
        skip_case(9'h020, 9'h000, 1'b0);
        skip_case(`OP_SKIP_ACC_EQUALS_MEM, 9'h000, 1'b0);
        bus_wr(`REG_RAM, 16'h0000);
        skip_case(`OP_SKIP_ACC_EQUALS_MEM, 9'h000, 1'b1);
        skip_case(`OP_SEA, 9'h0B0, 1'b1);
        skip_case(`OP_SEA, 9'h0B3, 1'b0);
        // a skipped two-word compare must not run its operand as a load
        bus_wr(`REG_ACC, 16'h0000);
        prog = {`OP_SKIP_ACC_EQUALS_MEM, `OP_SEA, 9'h0B5, 9'h0B7};
        run(7);
        bus_rd(`REG_ACC);
        check("two word skip", 16'(rd_val[3:0]), 16'h0007);
        @(posedge sys_clk);
        pwr_down_flag <= 1'b1;
        skip_case(`OP_SKIP_ON_POWERDOWN_FLAG, 9'h000, 1'b1);
        bus_rd(`REG_STATUS);
        check("power flag", 16'(rd_val[2]), 16'h0001);
        @(posedge sys_clk);
        pwr_down_flag <= 1'b0;
        skip_case(`OP_SKIP_ON_POWERDOWN_FLAG, 9'h000, 1'b0);
        pulse(1'b0);
        skip_case(`OP_SKIP_ON_TIMER1_UNDERFLOW, 9'h000, 1'b1);
        skip_case(`OP_SKIP_ON_TIMER1_UNDERFLOW, 9'h000, 1'b0);
        pulse(1'b1);
        skip_case(`OP_SKIP_ON_TIMER2_REQUEST, 9'h000, 1'b1);
        bus_rd(`REG_STATUS);
        check("timer flags", 16'(rd_val[1:0]), 16'h0000);
        skip_case(`OP_SKIP_ON_TIMER2_REQUEST, 9'h000, 1'b0);
        bus_wr(`REG_PTR, 16'h0005);
        @(posedge sys_clk);
        d_in <= 8'hDF;
        skip_case(`OP_SZD, 9'h02B, 1'b1);
        @(posedge sys_clk);
        d_in <= 8'h20;
        skip_case(`OP_SZD, 9'h02B, 1'b0);
    endtask : test_skips

    task automatic test_returns;
        bus_wr(`REG_PUSH, 16'h0102);
        bus_wr(`REG_ACC, 16'h0000);
        prog = {`OP_RT, 9'h0B6, 9'h0B7};
        run(0);
        @(posedge sys_clk);
        #1;
        check("pc after return", 16'(pc_addr), 16'h0102);
        @(posedge sys_clk);
        #1;
        check("pc idle cycle", 16'(pc_addr), 16'h0102);
        @(posedge sys_clk);
        #1;
        check("pc resumes", 16'(pc_addr), 16'h0103);
        bus_rd(`REG_PUSH);
        check("stack pointer", 16'(rd_val[1:0]), 16'h0000);
        bus_wr(`REG_PUSH, 16'h0102);
        prog = {`OP_RTS, 9'h000, 9'h0B6, 9'h0B7};
        run(6);
        bus_rd(`REG_ACC);
        check("return skip", 16'(rd_val[3:0]), 16'h0007);
    endtask : test_returns

    task automatic test_timers;
        bus_wr(`REG_CTRL, 16'h0000);
        bus_wr(`REG_ACC, 16'h005A);
        prog = {`OP_LOAD_TIMER1_FROM_REGS};
        run(2);
        bus_rd(`REG_TIMER1);
        check("timer1 stopped", rd_val, 16'h5A5A);
        bus_wr(`REG_ACC, 16'h0000);
        prog = {`OP_READ_TIMER1_TO_REGS};
        run(2);
        bus_rd(`REG_ACC);
        check("acc from t1", 16'(rd_val[7:0]), 16'h005A);
        bus_wr(`REG_CTRL, 16'h0004);
        bus_wr(`REG_ACC, 16'h003C);
        prog = {`OP_LOAD_TIMER1_FROM_REGS};
        run(2);
        bus_rd(`REG_TIMER1);
        check("t1 reload run", 16'(rd_val[15:8]), 16'h003C);
        check("t1 count kept", 16'(rd_val[7:0]), 16'h005A);
        bus_wr(`REG_CTRL, 16'h0000);
        bus_wr(`REG_ACC, 16'h0096);
        prog = {`OP_LOAD_TIMER2_AND_LOW_RELOAD};
        run(2);
        bus_rd(`REG_TIMER2);
        check("timer2 load", rd_val, 16'h9696);
        bus_wr(`REG_ACC, 16'h0021);
        prog = {`OP_LOAD_TIMER2_HIGH_RELOAD};
        run(2);
        bus_rd(`REG_T2HIGH);
        check("t2 high reload", 16'(rd_val[7:0]), 16'h0021);
        bus_rd(`REG_TIMER2);
        check("t2 untouched", rd_val, 16'h9696);
        bus_wr(`REG_TIMER2, 16'h0000);
        prog = {`OP_COPY_LOW_RELOAD_TO_TIMER2};
        run(2);
        bus_rd(`REG_TIMER2);
        check("t2 from reload", rd_val, 16'h9696);
        bus_wr(`REG_ACC, 16'h0000);
        prog = {`OP_READ_TIMER2_TO_REGS};
        run(2);
        bus_rd(`REG_ACC);
        check("acc from t2", 16'(rd_val[7:0]), 16'h0096);
    endtask : test_timers

    ////////////////////////////////////////////////////////////////////////////////////////
    // verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        rst           = 1'b1;
        bus           = '0;
        pwr_down_flag = 1'b0;
        t1_uflow      = 1'b0;
        t2_req        = 1'b0;
        d_in          = 8'h00;
        for (int i = 0; i < 2048; i++) rom[i] = 9'h000;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_logic();
        test_ports();
        test_skips();
        test_returns();
        test_timers();
        report_and_stop();
    end
endmodule : four_bit_exec_tb
`default_nettype wire
